// *** hw/srt_pkg.sv ***
// Constants shared by the serial unit register tail.
// Assumes one 250 MHz clock and a peripheral bus with byte addresses.
// What this block does
// R1: Soft reset raises busy until synchronised
// R2: Writes during synchronisation discarded with bus error
// R3: Match mask held in bits 23:16
// R4: Match target held in bits 7:0
// R5: Unused bits read zero; software writes zero
// R6: Data read returns receive buffer
// R7: Data write loads transmit buffer
// R8: Software reads data only when receive done
// R9: Software writes data only when transmit empty
// R10: Debug halt bit stops baud generator
// R11: Core clock requested while operating as master
// R12: Control enable writes synchronised before taking effect; master bit stored at once while disabled
// R13: Match register writable only while disabled
package srt_pkg;
    // Timing
    localparam int CLK_PERIOD_NS = 4;
    localparam int SYNC_TIME_NS  = 24;
    localparam int SYNC_CYCLES   =
        (SYNC_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int BAUD_DIV      = 4;

    // Register offsets
    localparam logic [7:0] OFF_CTRL  = 8'h00;
    localparam logic [7:0] OFF_FLAGS = 8'h18;
    localparam logic [7:0] OFF_SYNC  = 8'h1c;
    localparam logic [7:0] OFF_MATCH = 8'h24;
    localparam logic [7:0] OFF_DATA  = 8'h28;
    localparam logic [7:0] OFF_DBG   = 8'h30;

    // Field positions
    localparam int CTRL_RESET_BIT  = 0;
    localparam int CTRL_ENABLE_BIT = 1;
    localparam int CTRL_MASTER_BIT = 2;
    localparam int FLAG_TXE_BIT    = 0;
    localparam int FLAG_RXD_BIT    = 2;
    localparam int SYNC_RESET_BIT  = 0;
    localparam int SYNC_ENABLE_BIT = 1;
    localparam int MASK_LSB        = 16;
    localparam int MASK_MSB        = 23;
    localparam int TGT_LSB         = 0;
    localparam int TGT_MSB         = 7;
    localparam int DATA_W          = 9;

    // Reset values
    localparam logic [7:0]        MASK_RST = 8'h00;
    localparam logic [7:0]        TGT_RST  = 8'h00;
    localparam logic [DATA_W-1:0] DATA_RST = 9'h000;
    localparam logic              DBG_RST  = 1'h0;
    localparam logic              TXE_RST  = 1'h1;

    typedef enum logic [1:0] {
        SRT_SYNC_IDLE = 2'b00,
        SRT_SYNC_RST  = 2'b01,
        SRT_SYNC_EN   = 2'b10
    } srt_sync_t;
endpackage : srt_pkg

// *** hw/srt_sync_timer.sv ***
// Fixed-length busy window for control synchronisation.
// Assumes start is a one-cycle pulse given only while idle.
`timescale 1ns/1ns
`default_nettype none
module srt_sync_timer #(
    parameter int CYCLES = 6
) (
    // Clock and reset
    input  wire logic clk,
    input  wire logic reset,
    // Control
    input  wire logic start,
    output var  logic busy,
    output var  logic done
);
    localparam int CW = $clog2(CYCLES + 1);
    localparam logic [CW-1:0] ONE = CW'(1);

    logic [CW-1:0] count_q;

    always_ff @(posedge clk) begin
        if (reset) begin
            count_q <= '0;
            busy    <= 1'b0;
            done    <= 1'b0;
        end else begin
            done <= 1'b0;
            if (start && !busy) begin
                count_q <= CW'(CYCLES);
                busy    <= 1'b1;
            end else if (busy) begin
                count_q <= count_q - ONE;
                if (count_q == ONE) begin
                    busy <= 1'b0;
                    done <= 1'b1;
                end
            end
        end
    end
endmodule : srt_sync_timer
`default_nettype wire

// *** hw/srt_regs.sv ***
// Register tail of the serial unit: control, sync busy, match, data, debug.
// Assumes the shifter gives rxValid/txTaken pulses on this same clock.
`timescale 1ns/1ns
`default_nettype none
module srt_regs #(
    parameter int SYNC_CYCLES = srt_pkg::SYNC_CYCLES,
    parameter int BAUD_DIV    = srt_pkg::BAUD_DIV
) (
    // Clock and reset
    input  wire logic                      clk,
    input  wire logic                      reset,
    // Peripheral bus
    input  wire logic                      psel,
    input  wire logic                      penable,
    input  wire logic                      pwrite,
    input  wire logic [7:0]                paddr,
    input  wire logic [31:0]               pwdata,
    output var  logic [31:0]               prdata,
    output var  logic                      pready,
    output var  logic                      pslverr,
    // Shifter side
    input  wire logic                      rxValid,
    input  wire logic [srt_pkg::DATA_W-1:0] rxData,
    input  wire logic                      txTaken,
    output var  logic [srt_pkg::DATA_W-1:0] txData,
    output var  logic                      txLoad,
    output var  logic [7:0]                matchMask,
    output var  logic [7:0]                matchTarget,
    // Unit control
    input  wire logic                      debugHalt,
    output var  logic                      unitEnable,
    output var  logic                      coreClockRequest,
    output var  logic                      baudTick
);
    localparam int BW = $clog2(BAUD_DIV + 1);
    localparam logic [BW-1:0] BAUD_LAST = BW'(BAUD_DIV - 1);
    localparam logic [BW-1:0] BONE      = BW'(1);
    localparam int SyncMax = SYNC_CYCLES + 2;

    srt_pkg::srt_sync_t syncState_q;
    logic                       enable_q, pendEnable_q, master_q;
    logic [7:0]                 mask_q, target_q;
    logic [srt_pkg::DATA_W-1:0] txBuf_q, rxBuf_q;
    logic                       txEmpty_q, rxDone_q, haltOnDebug_q;
    logic                       txLoad_q, coreReq_q, baudTick_q;
    logic [BW-1:0]              baudCnt_q;
    logic [31:0]                prdata_q, rdWord;
    logic                       pready_q, pslverr_q;
    logic                       accept, wrAcc, rdAcc, busyAny, wrOk;
    logic                       timerBusy, timerDone, syncStart;
    logic                       softClear, softStart, enStart, baudRun;
    logic                       hit;

    assign accept  = psel && penable && !pready_q;
    assign wrAcc   = accept && pwrite;
    assign rdAcc   = accept && !pwrite;
    assign busyAny = syncState_q != srt_pkg::SRT_SYNC_IDLE;
    assign wrOk    = wrAcc && !busyAny;
    assign softStart = wrOk && paddr == srt_pkg::OFF_CTRL
                       && pwdata[srt_pkg::CTRL_RESET_BIT];
    assign enStart = wrOk && paddr == srt_pkg::OFF_CTRL
                     && !pwdata[srt_pkg::CTRL_RESET_BIT]
                     && pwdata[srt_pkg::CTRL_ENABLE_BIT] != enable_q;
    assign syncStart = softStart || enStart;
    assign softClear = timerDone && syncState_q == srt_pkg::SRT_SYNC_RST;
    assign baudRun   = !(haltOnDebug_q && debugHalt);

    srt_sync_timer #(
        .CYCLES (SYNC_CYCLES)
    ) u_timer (
        .clk   (clk),
        .reset (reset),
        .start (syncStart),
        .busy  (timerBusy),
        .done  (timerDone)
    );

    // Control reset and enable writes wait out the crossing before they act
    always_ff @(posedge clk) begin
        if (reset) begin
            syncState_q  <= srt_pkg::SRT_SYNC_IDLE;
            enable_q     <= 1'b0;
            pendEnable_q <= 1'b0;
        end else begin
            case (syncState_q)
                srt_pkg::SRT_SYNC_IDLE: begin
                    if (softStart) begin
                        syncState_q <= srt_pkg::SRT_SYNC_RST; // R1
                    end else if (enStart) begin
                        syncState_q  <= srt_pkg::SRT_SYNC_EN; // R12
                        pendEnable_q <= pwdata[srt_pkg::CTRL_ENABLE_BIT];
                    end
                end
                srt_pkg::SRT_SYNC_RST: begin
                    if (timerDone) begin
                        syncState_q <= srt_pkg::SRT_SYNC_IDLE; // R1
                        enable_q    <= 1'b0;
                    end
                end
                srt_pkg::SRT_SYNC_EN: begin
                    if (timerDone) begin
                        syncState_q <= srt_pkg::SRT_SYNC_IDLE;
                        enable_q    <= pendEnable_q; // R12
                    end
                end
                default: syncState_q <= srt_pkg::SRT_SYNC_IDLE;
            endcase
        end
    end

    // Mode bit and match fields are frozen while enabled
    always_ff @(posedge clk) begin
        if (reset || softClear) begin
            master_q <= 1'b0;
            mask_q   <= srt_pkg::MASK_RST;
            target_q <= srt_pkg::TGT_RST;
        end else if (wrOk && !enable_q) begin // R13
            if (paddr == srt_pkg::OFF_CTRL) begin
                master_q <= pwdata[srt_pkg::CTRL_MASTER_BIT];
            end
            if (paddr == srt_pkg::OFF_MATCH) begin
                mask_q   <= pwdata[srt_pkg::MASK_MSB:srt_pkg::MASK_LSB]; // R3
                target_q <= pwdata[srt_pkg::TGT_MSB:srt_pkg::TGT_LSB]; // R4
            end
        end
    end

    // Core clock follows master operation
    always_ff @(posedge clk) begin
        if (reset) begin
            coreReq_q <= 1'b0;
        end else begin
            coreReq_q <= enable_q && master_q; // R11
        end
    end

    // Transmit buffer; taken-by-shifter wins over a same-cycle load
    always_ff @(posedge clk) begin
        if (reset || softClear) begin
            txBuf_q   <= srt_pkg::DATA_RST;
            txEmpty_q <= srt_pkg::TXE_RST;
            txLoad_q  <= 1'b0;
        end else begin
            txLoad_q <= 1'b0;
            if (wrOk && paddr == srt_pkg::OFF_DATA) begin
                txBuf_q  <= pwdata[srt_pkg::DATA_W-1:0]; // R7
                txLoad_q <= 1'b1;
            end
            if (txTaken) begin
                txEmpty_q <= 1'b1;
            end else if (wrOk && paddr == srt_pkg::OFF_DATA) begin
                txEmpty_q <= 1'b0;
            end
        end
    end

    // Receive buffer; new data wins over a same-cycle read clear
    always_ff @(posedge clk) begin
        if (reset || softClear) begin
            rxBuf_q  <= srt_pkg::DATA_RST;
            rxDone_q <= 1'b0;
        end else begin
            if (rxValid) begin
                rxBuf_q  <= rxData;
                rxDone_q <= 1'b1;
            end else if (rdAcc && paddr == srt_pkg::OFF_DATA) begin
                rxDone_q <= 1'b0;
            end
        end
    end

    // Debug control survives a soft reset
    always_ff @(posedge clk) begin
        if (reset) begin
            haltOnDebug_q <= srt_pkg::DBG_RST;
        end else if (wrOk && paddr == srt_pkg::OFF_DBG) begin
            haltOnDebug_q <= pwdata[0];
        end
    end

    // Baud generator freezes in place so it resumes mid-period
    always_ff @(posedge clk) begin
        if (reset || !enable_q) begin
            baudCnt_q  <= '0;
            baudTick_q <= 1'b0;
        end else begin
            baudTick_q <= 1'b0;
            if (baudRun) begin // R10
                if (baudCnt_q == BAUD_LAST) begin
                    baudCnt_q  <= '0;
                    baudTick_q <= 1'b1;
                end else begin
                    baudCnt_q <= baudCnt_q + BONE;
                end
            end
        end
    end

    // Read mux; every unused bit is zero
    always_comb begin
        rdWord = '0; // R5
        hit    = 1'b1;
        case (paddr)
            srt_pkg::OFF_CTRL: begin
                rdWord[srt_pkg::CTRL_ENABLE_BIT] = enable_q;
                rdWord[srt_pkg::CTRL_MASTER_BIT] = master_q;
            end
            srt_pkg::OFF_FLAGS: begin
                rdWord[srt_pkg::FLAG_TXE_BIT] = txEmpty_q;
                rdWord[srt_pkg::FLAG_RXD_BIT] = rxDone_q;
            end
            srt_pkg::OFF_SYNC: begin
                rdWord[srt_pkg::SYNC_RESET_BIT] =
                    syncState_q == srt_pkg::SRT_SYNC_RST; // R1
                rdWord[srt_pkg::SYNC_ENABLE_BIT] =
                    syncState_q == srt_pkg::SRT_SYNC_EN;
            end
            srt_pkg::OFF_MATCH: begin
                rdWord[srt_pkg::MASK_MSB:srt_pkg::MASK_LSB] = mask_q;
                rdWord[srt_pkg::TGT_MSB:srt_pkg::TGT_LSB]   = target_q;
            end
            srt_pkg::OFF_DATA: rdWord[srt_pkg::DATA_W-1:0] = rxBuf_q; // R6
            srt_pkg::OFF_DBG:  rdWord[0] = haltOnDebug_q;
            default:           hit = 1'b0;
        endcase
    end

    // One wait state; answer registered so outputs come from flops
    always_ff @(posedge clk) begin
        if (reset) begin
            pready_q  <= 1'b0;
            pslverr_q <= 1'b0;
            prdata_q  <= '0;
        end else begin
            pready_q  <= accept;
            pslverr_q <= accept && (!hit || (pwrite && busyAny)); // R2
            prdata_q  <= (rdAcc && hit) ? rdWord : '0;
        end
    end

    assign prdata           = prdata_q;
    assign pready           = pready_q;
    assign pslverr          = pslverr_q;
    assign txData           = txBuf_q;
    assign txLoad           = txLoad_q;
    assign matchMask        = mask_q;
    assign matchTarget      = target_q;
    assign unitEnable       = enable_q;
    assign coreClockRequest = coreReq_q;
    assign baudTick         = baudTick_q;

    default clocking cb @(posedge clk); endclocking
    default disable iff (reset);

    sequence busyWindow;
        (syncState_q == srt_pkg::SRT_SYNC_RST) ##[1:SyncMax]
            (syncState_q == srt_pkg::SRT_SYNC_IDLE);
    endsequence

    reset_busy_a: assert property (softStart |=> busyWindow) // R1
        else $error("soft reset busy window wrong");
    busy_error_a: assert property (wrAcc && busyAny |=> pready_q && pslverr_q) // R2
        else $error("write during sync not errored");
    // The soft reset may clear both in the very cycle a refused write lands
    busy_discard_a: assert property ( // R2
        wrAcc && busyAny |=>
            txBuf_q == ($past(softClear) ? srt_pkg::DATA_RST : $past(txBuf_q))
        && mask_q == ($past(softClear) ? srt_pkg::MASK_RST : $past(mask_q)))
        else $error("write during sync not discarded");
    match_mask_a: assert property (wrOk && !enable_q && paddr == srt_pkg::OFF_MATCH |=> mask_q == $past(pwdata[23:16])) // R3
        else $error("match mask not stored");
    match_target_a: assert property (wrOk && !enable_q && paddr == srt_pkg::OFF_MATCH |=> target_q == $past(pwdata[7:0])) // R4
        else $error("match target not stored");
    reserved_zero_a: assert property (rdAcc && paddr == srt_pkg::OFF_MATCH |=> prdata_q[31:24] == 8'h00 && prdata_q[15:8] == 8'h00) // R5
        else $error("reserved bits not zero");
    rx_read_a: assert property (rdAcc && paddr == srt_pkg::OFF_DATA |=> prdata_q == {23'h000000, $past(rxBuf_q)}) // R6
        else $error("data read wrong");
    tx_write_a: assert property (wrOk && paddr == srt_pkg::OFF_DATA |=> txLoad_q && txBuf_q == $past(pwdata[8:0])) // R7
        else $error("transmit load wrong");
    debug_halt_a: assert property ( // R10
        haltOnDebug_q && debugHalt |=> !baudTick_q
        && baudCnt_q == ($past(enable_q) ? $past(baudCnt_q) : BW'(0)))
        else $error("baud not halted");
    core_clock_a: assert property (enable_q && master_q |=> coreReq_q) // R11
        else $error("core clock not requested");
    enable_sync_a: assert property (enStart |=> $stable(enable_q) [*4]) // R12
        else $error("enable acted before sync");
    match_protect_a: assert property ( // R13
        wrAcc && enable_q && paddr == srt_pkg::OFF_MATCH |=>
            mask_q == ($past(softClear) ? srt_pkg::MASK_RST : $past(mask_q))
        && target_q == ($past(softClear) ? srt_pkg::TGT_RST : $past(target_q)))
        else $error("protected match write taken");
    timer_track_a: assert property (timerBusy |-> busyAny) // R12
        else $error("sync timer running while idle");
endmodule : srt_regs
`default_nettype wire

// *** tb/srt_peer_model.sv ***
// Loopback model of the serial peer behind the shifter side.
// Assumes txLoad is a one-cycle pulse from the register tail.
`timescale 1ns/1ns
`default_nettype none
module srt_peer_model #(
    parameter int DELAY = 3
) (
    // Clock and reset
    input  wire logic                       clk,
    input  wire logic                       reset,
    // Register tail side
    input  wire logic                       txLoad,
    input  wire logic [srt_pkg::DATA_W-1:0] txData,
    output var  logic                       txTaken,
    output var  logic                       rxValid,
    output var  logic [srt_pkg::DATA_W-1:0] rxData
);
    logic [srt_pkg::DATA_W-1:0] held;
    int                         waitCnt;
    // Data toggles outside the valid pulse so a stale sample shows up
    always_ff @(posedge clk) begin
        txTaken <= 1'b0;
        rxValid <= 1'b0;
        rxData  <= ~rxData;
        if (reset) begin
            waitCnt <= 0;
            rxData  <= 9'h000;
        end else if (txLoad) begin
            held    <= txData;
            waitCnt <= DELAY;
        end else if (waitCnt == 1) begin
            waitCnt <= 0;
            txTaken <= 1'b1;
            rxValid <= 1'b1;
            rxData  <= held;
        end else if (waitCnt > 1) begin
            waitCnt <= waitCnt - 1;
        end
    end
endmodule : srt_peer_model
`default_nettype wire

// *** tb/spi_register_tail_tb_top.sv ***
// Self-checking bench for the serial unit register tail.
// Assumes one bus wait state and a loopback peer on the shifter side.
`timescale 1ns/1ns
`default_nettype none
module spi_register_tail_tb_top;
    logic                       clk, reset, psel, penable, pwrite;
    logic                       pready, pslverr, debugHalt, rerr;
    logic                       rxValid, txTaken, txLoad, baudTick;
    logic                       unitEnable, coreClockRequest;
    logic [7:0]                 paddr, matchMask, matchTarget;
    logic [31:0]                pwdata, prdata, rdat;
    logic [srt_pkg::DATA_W-1:0] rxData, txData;
    int                         miscompares, numChecks, n;

    // Long sync window so refused writes land inside it
    srt_regs #(.SYNC_CYCLES(12), .BAUD_DIV(4)) i_dut (
        .clk(clk), .reset(reset), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .rxValid(rxValid), .rxData(rxData), .txTaken(txTaken),
        .txData(txData), .txLoad(txLoad), .matchMask(matchMask),
        .matchTarget(matchTarget), .debugHalt(debugHalt),
        .unitEnable(unitEnable), .coreClockRequest(coreClockRequest),
        .baudTick(baudTick)
    );
    srt_peer_model i_peer (
        .clk(clk), .reset(reset), .txLoad(txLoad), .txData(txData),
        .txTaken(txTaken), .rxValid(rxValid), .rxData(rxData)
    );

    task automatic print_verdict;
        $display("checks %0d mismatches %0d", numChecks, miscompares);
        if (miscompares == 0 && numChecks > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask : print_verdict

    task automatic chk(input string nm, input logic [31:0] seen, exp);
        numChecks++;
        if (seen !== exp) begin
            miscompares++;
            $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
        end
    endtask : chk

    task automatic give_up(input string nm);
        miscompares++;
        $display("[FAIL] %s expected done seen timeout", nm);
        print_verdict();
    endtask : give_up

    task automatic apb(input logic w, input logic [7:0] a,
                       input logic [31:0] d);
        @(negedge clk);
        psel = 1'b1;
        pwrite = w;
        paddr = a;
        pwdata = d;
        @(negedge clk);
        penable = 1'b1;
        for (int i = 0; i < 8; i++) begin
            @(posedge clk);
            if (pready === 1'b1) break;
            if (i == 7) give_up("pready");
        end
        rdat = prdata;
        rerr = pslverr;
        @(negedge clk);
        psel = 1'b0;
        penable = 1'b0;
    endtask : apb

    task automatic wr(input logic [7:0] a, input logic [31:0] d,
                      input logic e);
        apb(1'b1, a, d);
        chk("write error", {31'h0, rerr}, {31'h0, e});
    endtask : wr

    task automatic rd(input string nm, input logic [7:0] a,
                      input logic [31:0] exp);
        apb(1'b0, a, 32'h0);
        chk(nm, rdat, exp);
        chk("read error", {31'h0, rerr}, 32'h0);
    endtask : rd

    task automatic poll(input string nm, input logic [7:0] a,
                        input logic [31:0] m, want);
        for (int i = 0; i < 20; i++) begin
            apb(1'b0, a, 32'h0);
            if ((rdat & m) === want) break;
            if (i == 19) give_up(nm);
        end
    endtask : poll

    task automatic ticks(input logic h, input int exp);
        @(negedge clk);
        debugHalt = h;
        repeat (4) @(posedge clk);
        n = 0;
        repeat (16) begin
            @(posedge clk);
            if (baudTick === 1'b1) n++;
        end
        chk("baud ticks", n, exp);
    endtask : ticks

    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end

    initial begin
        miscompares = 0;
        numChecks = 0;
        reset = 1'b1;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0;
        debugHalt = 1'b0;
        repeat (16) @(negedge clk);
        reset = 1'b0;
        rd("match reset", srt_pkg::OFF_MATCH, 32'h0);
        rd("data reset", srt_pkg::OFF_DATA, 32'h0);
        rd("debug reset", srt_pkg::OFF_DBG, 32'h0);
        rd("flags reset", srt_pkg::OFF_FLAGS, 32'h1);
        rd("sync reset", srt_pkg::OFF_SYNC, 32'h0);
        apb(1'b0, 8'h04, 32'h0);
        chk("unmapped error", {31'h0, rerr}, 32'h1);
        chk("unmapped data", rdat, 32'h0);
        $display("test reset values done");
        wr(srt_pkg::OFF_MATCH, 32'h00a5005c, 1'b0);
        rd("match", srt_pkg::OFF_MATCH, 32'h00a5005c);
        chk("mask pins", {24'h0, matchMask}, 32'ha5);
        chk("target pins", {24'h0, matchTarget}, 32'h5c);
        $display("test match fields done");
        wr(srt_pkg::OFF_DATA, 32'h000001a5, 1'b0);
        chk("tx buffer", {23'h0, txData}, 32'h1a5);
        poll("rx done", srt_pkg::OFF_FLAGS, 32'h4, 32'h4);
        rd("rx buffer", srt_pkg::OFF_DATA, 32'h1a5);
        rd("flags idle", srt_pkg::OFF_FLAGS, 32'h1);
        $display("test data loopback done");
        wr(srt_pkg::OFF_CTRL, 32'h6, 1'b0);
        wr(srt_pkg::OFF_DBG, 32'h1, 1'b1);
        rd("enable busy", srt_pkg::OFF_SYNC, 32'h2);
        chk("enable late", {31'h0, unitEnable}, 32'h0);
        poll("enable sync", srt_pkg::OFF_SYNC, 32'h3, 32'h0);
        chk("enabled", {31'h0, unitEnable}, 32'h1);
        chk("core clock", {31'h0, coreClockRequest}, 32'h1);
        rd("debug dropped", srt_pkg::OFF_DBG, 32'h0);
        wr(srt_pkg::OFF_MATCH, 32'h00110022, 1'b0);
        rd("match locked", srt_pkg::OFF_MATCH, 32'h00a5005c);
        $display("test enable sync done");
        ticks(1'b1, 4);
        wr(srt_pkg::OFF_DBG, 32'h1, 1'b0);
        ticks(1'b1, 0);
        ticks(1'b0, 4);
        $display("test debug halt done");
        // Reset bit set, so only the reset sync starts; the enable and master bits in this write are ignored
        wr(srt_pkg::OFF_CTRL, 32'h7, 1'b0);
        rd("reset busy", srt_pkg::OFF_SYNC, 32'h1);
        wr(srt_pkg::OFF_MATCH, 32'h0, 1'b1);
        poll("reset sync", srt_pkg::OFF_SYNC, 32'h3, 32'h0);
        rd("match cleared", srt_pkg::OFF_MATCH, 32'h0);
        rd("debug kept", srt_pkg::OFF_DBG, 32'h1);
        chk("disabled", {31'h0, unitEnable}, 32'h0);
        $display("test soft reset done");
        print_verdict();
    end
endmodule : spi_register_tail_tb_top
`default_nettype wire
